// ===== thermal_restart_map.svh
// register offsets, field positions, reset values and timing counts of the thermal restart unit
`ifndef THERMAL_RESTART_MAP_SVH
`define THERMAL_RESTART_MAP_SVH

// ==========================================
// register word indices, byte address is index times four (documented offsets are not word aligned, so they are indices)
`define TR_OPTION_IDX 16'h1802
`define TR_STATUS_IDX 16'h180f
`define TR_IRQ_STAT_IDX 16'h1810
`define TR_IRQ_CLR_IDX 16'h1811
`define TR_IRQ_EN_IDX 16'h1812
`define TR_ADDR_W 18

// ==========================================
// field positions
`define TR_ENABLE_BIT 3
`define TR_HIGH_SEL_BIT 2
`define TR_OUTSIDE_BIT 0
`define TR_EV_ARMED 0
`define TR_EV_FIRED 1
`define TR_EV_OUTSIDE 2
`define TR_EV_REFUSED 3
`define TR_EV_W 4

// ==========================================
// reset values and timing
`define TR_OPTION_RST 8'h00
`define TR_OUTSIDE_RST 1'b1
`define TR_CLK_HZ 20000000
`define TR_RESET_MIN_NS 50
`define TR_RESET_CYCLES ((`TR_RESET_MIN_NS * (`TR_CLK_HZ / 1000000) + 999) / 1000)
`define TR_VECTOR_ADDR 16'hdffe

`endif

// ===== thermal_restart_pkg.sv
// types shared by the thermal restart unit
package thermal_restart_pkg;
   typedef enum logic [1:0] {st_idle, st_armed, st_fire} restart_state_t;
endpackage : thermal_restart_pkg

// ===== sync_two_stage.sv
// two flip-flop synchroniser for asynchronous levels
`timescale 1ns/1ps
module sync_two_stage #(
   parameter int WIDTH = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta;

   initial begin
      if (WIDTH < 1) $error("sync_two_stage: WIDTH must be at least 1");
   end

   // no clock enable here: the synchroniser must keep tracking the comparators
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= '0;
         sync_out <= '0;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule : sync_two_stage

// ===== thermal_restart_control.sv
// thermal restart unit: option and status registers, arming, restart reset and wakeup suppression
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "thermal_restart_map.svh"

// Notes on behaviour
// - option register bit 3 turns the restart unit on or off.
// - restart enable clears on every MCU reset.
// - select bit one picks high threshold, zero picks low threshold.
// - threshold select clears on every MCU reset.
// - a fired restart resets the MCU, which resumes at its reset vector.
// - no restart reset unless temperature first left the re-arm window.
// - outside-rearm status reads at bit 0 of the test register.
// - outside-rearm status is forced to one on every MCU reset.
// - with status one and enable set, return to recovery window restarts MCU.
// - with status zero, writes setting the enable bit are ignored.
// - rising past re-arm threshold sets status; falling past recovery clears it.
// - during shutdown, periodic wakeup and periodic reset are blocked.
// - suppression only while active and status one; counters keep running.
module thermal_restart_control #(
   parameter int RESET_CYCLES = `TR_RESET_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rearm_high_crossed,
   input wire logic recovery_high_crossed,
   input wire logic rearm_low_crossed,
   input wire logic recovery_low_crossed,
   input wire logic wake_request,
   input wire logic periodic_reset_request,
   output logic wake_irq,
   output logic periodic_reset,
   output logic restart_reset,
   output logic [15:0] restart_vector,
   output logic unit_powered,
   output logic irq
);
   // ==========================================
   // parameter checks
   initial begin
      if (RESET_CYCLES < 1) $error("thermal_restart_control: RESET_CYCLES must be at least 1");
      if (RESET_CYCLES > 255) $error("thermal_restart_control: RESET_CYCLES exceeds counter");
   end

   // ==========================================
   // state
   logic thermal_restart_enable;
   logic high_threshold_select;
   logic outside_rearm_status;
   logic [`TR_EV_W-1:0] irq_status;
   logic [`TR_EV_W-1:0] irq_enable;
   logic [7:0] reset_count;
   thermal_restart_pkg::restart_state_t state;
   thermal_restart_pkg::restart_state_t next_state;
   logic [3:0] crossings;

   // ==========================================
   // crossing inputs enter the bus clock domain
   sync_two_stage #(.WIDTH(4)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({recovery_low_crossed, rearm_low_crossed, recovery_high_crossed, rearm_high_crossed}),
      .sync_out(crossings)
   );

   wire rearm_cross = high_threshold_select ? crossings[0] : crossings[2];
   wire recovery_cross = high_threshold_select ? crossings[1] : crossings[3];

   // ==========================================
   // bus decode
   function automatic logic hit(input logic [31:0] a, input logic [15:0] idx);
      hit = (a[31:2] == {14'h0000, idx});
   endfunction : hit

   // read data is captured in the first access cycle so it stands with pready;
   // writes land only at the edge that sees pready high, as the master expects
   wire first_access = psel && penable && !pready && clk_en;
   wire commit = psel && penable && pready && clk_en;
   wire wr = commit && pwrite;
   wire rd = first_access && !pwrite;
   wire sel_opt = hit(paddr, `TR_OPTION_IDX);
   wire sel_stat = hit(paddr, `TR_STATUS_IDX);
   wire sel_ist = hit(paddr, `TR_IRQ_STAT_IDX);
   wire sel_icl = hit(paddr, `TR_IRQ_CLR_IDX);
   wire sel_ien = hit(paddr, `TR_IRQ_EN_IDX);
   wire mapped = sel_opt || sel_stat || sel_ist || sel_icl || sel_ien;
   wire wr_opt = wr && sel_opt;
   // a set attempt is dropped while the unit is still inside the recovery window
   wire en_allowed = outside_rearm_status;
   wire next_enable_wr = pwdata[`TR_ENABLE_BIT] && en_allowed;
   wire refused = wr_opt && pwdata[`TR_ENABLE_BIT] && !en_allowed;

   logic [31:0] rd_value;
   always_comb begin
      if (sel_opt) begin
         rd_value = {28'h0000000, thermal_restart_enable, high_threshold_select, 2'h0};
      end else if (sel_stat) begin
         rd_value = {31'h00000000, outside_rearm_status};
      end else if (sel_ist) begin
         rd_value = {28'h0000000, irq_status};
      end else if (sel_ien) begin
         rd_value = {28'h0000000, irq_enable};
      end else begin
         rd_value = 32'h00000000;
      end
   end

   // ==========================================
   // restart sequencer
   // the enable bit itself arms the unit, so a recovery in the cycle after arming is not lost
   wire fire = (state != thermal_restart_pkg::st_fire) && thermal_restart_enable && recovery_cross
      && outside_rearm_status;
   wire done = (state == thermal_restart_pkg::st_fire) && (reset_count == 8'(RESET_CYCLES - 1));

   always_comb begin
      next_state = state;
      case (state)
         thermal_restart_pkg::st_idle: begin
            if (fire) next_state = thermal_restart_pkg::st_fire;
            else if (thermal_restart_enable) next_state = thermal_restart_pkg::st_armed;
         end
         thermal_restart_pkg::st_armed: begin
            if (!thermal_restart_enable) next_state = thermal_restart_pkg::st_idle;
            else if (fire) next_state = thermal_restart_pkg::st_fire;
         end
         thermal_restart_pkg::st_fire: begin
            if (done) next_state = thermal_restart_pkg::st_idle;
         end
         default: next_state = thermal_restart_pkg::st_idle;
      endcase
   end

   wire suppress = thermal_restart_enable && outside_rearm_status;
   wire [`TR_EV_W-1:0] events = {refused, rearm_cross && !outside_rearm_status, fire,
      thermal_restart_enable == 1'b0 && wr_opt && next_enable_wr};
   // the restart reset clears enable and threshold select and forces outside status to one as an MCU reset does; interrupt status and enable keep their values
   wire mcu_reset = done;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= thermal_restart_pkg::st_idle;
         reset_count <= 8'h00;
      end else if (clk_en) begin
         state <= next_state;
         // counts cycles already spent in st_fire, so the pulse lasts exactly RESET_CYCLES
         if (state == thermal_restart_pkg::st_fire && next_state == thermal_restart_pkg::st_fire) begin
            reset_count <= reset_count + 8'h01;
         end else begin
            reset_count <= 8'h00;
         end
      end
   end

   // ==========================================
   // option and status bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         thermal_restart_enable <= 1'b0;
         high_threshold_select <= 1'b0;
      end else if (clk_en) begin
         if (mcu_reset) begin
            thermal_restart_enable <= 1'b0;
            high_threshold_select <= 1'b0;
         end else if (wr_opt) begin
            thermal_restart_enable <= next_enable_wr;
            high_threshold_select <= pwdata[`TR_HIGH_SEL_BIT];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         outside_rearm_status <= `TR_OUTSIDE_RST;
      end else if (clk_en) begin
         if (mcu_reset) outside_rearm_status <= `TR_OUTSIDE_RST;
         else if (rearm_cross) outside_rearm_status <= 1'b1;
         else if (recovery_cross) outside_rearm_status <= 1'b0;
      end
   end

   // ==========================================
   // interrupt status: hardware set wins over software clear
   wire [`TR_EV_W-1:0] clr = (wr && sel_icl) ? pwdata[`TR_EV_W-1:0] : '0;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= '0;
         irq_enable <= '0;
      end else if (clk_en) begin
         irq_status <= (irq_status & ~clr) | events;
         if (wr && sel_ien) irq_enable <= pwdata[`TR_EV_W-1:0];
      end
   end

   // ==========================================
   // registered outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         wake_irq <= 1'b0;
         periodic_reset <= 1'b0;
         restart_reset <= 1'b0;
         restart_vector <= `TR_VECTOR_ADDR;
         unit_powered <= 1'b0;
         irq <= 1'b0;
      end else if (clk_en) begin
         // one wait state: ready rises in the second access cycle
         pready <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !mapped;
         if (rd) prdata <= rd_value;
         // the timer's counters are outside; only its outputs are gated
         wake_irq <= wake_request && !periodic_reset_request && !suppress;
         periodic_reset <= periodic_reset_request && !suppress;
         restart_reset <= (next_state == thermal_restart_pkg::st_fire);
         restart_vector <= `TR_VECTOR_ADDR;
         unit_powered <= thermal_restart_enable;
         irq <= |((irq_status | events) & irq_enable);
      end
   end
endmodule : thermal_restart_control

// ===== thermal_restart_assertions.sv
// port checker for the thermal restart unit
`timescale 1ns/1ps
module thermal_restart_assertions #(
   parameter int RESET_CYCLES = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic wake_request,
   input wire logic periodic_reset_request,
   input wire logic wake_irq,
   input wire logic periodic_reset,
   input wire logic restart_reset,
   input wire logic [15:0] restart_vector,
   input wire logic unit_powered
);
   // ==========
   // length, arming, disarming and vector of the restart pulse
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   int hi_cnt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) hi_cnt <= 0;
      else hi_cnt <= restart_reset ? hi_cnt + 1 : 0;
   end
   property p_len; $fell(restart_reset) |-> hi_cnt == RESET_CYCLES; endproperty
   a_len: assert property (p_len) else $error("restart pulse length wrong");
   property p_arm; $rose(restart_reset) |-> ##[0:1] unit_powered; endproperty
   a_arm: assert property (p_arm) else $error("restart while disarmed");
   property p_disarm; $rose(restart_reset) |-> ##[1:3] !unit_powered; endproperty
   a_disarm: assert property (p_disarm) else $error("enable kept over restart");
   property p_vec; restart_vector == 16'hdffe; endproperty
   a_vec: assert property (p_vec) else $error("vector wrong");
   // powered implies outside status, since recovery fires the restart
   // unit_powered and the gated outputs are both one register behind the enable bit
   property p_wsup;
      unit_powered && $past(clk_en) && !restart_reset && !$past(restart_reset) |-> !wake_irq;
   endproperty
   a_wsup: assert property (p_wsup) else $error("wake not held off");
   property p_psup;
      unit_powered && $past(clk_en) && !restart_reset && !$past(restart_reset) |-> !periodic_reset;
   endproperty
   a_psup: assert property (p_psup) else $error("periodic reset not held off");
   property p_wpass;
      !unit_powered && $past(clk_en) && $past(wake_request) && !$past(periodic_reset_request)
         && !$past(restart_reset) |-> wake_irq;
   endproperty
   a_wpass: assert property (p_wpass) else $error("wake lost");
   property p_ppass;
      !unit_powered && $past(clk_en) && $past(periodic_reset_request) && !$past(restart_reset)
         |-> periodic_reset;
   endproperty
   a_ppass: assert property (p_ppass) else $error("periodic reset lost");
   c_rst: cover property ($rose(restart_reset));
   c_wake: cover property (wake_irq);
   c_per: cover property (periodic_reset);
endmodule : thermal_restart_assertions

bind thermal_restart_control thermal_restart_assertions #(.RESET_CYCLES(RESET_CYCLES)) u_thermal_restart_assertions (
   .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .wake_request(wake_request),
   .periodic_reset_request(periodic_reset_request), .wake_irq(wake_irq), .periodic_reset(periodic_reset),
   .restart_reset(restart_reset), .restart_vector(restart_vector), .unit_powered(unit_powered));

// ===== thermal_sensor_model.sv
// comparators and wakeup timer standing beside the restart unit
`timescale 1ns/1ps
module thermal_sensor_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [1:0] zone,
   output logic rearm_high_crossed,
   output logic recovery_high_crossed,
   output logic rearm_low_crossed,
   output logic recovery_low_crossed,
   output logic wake_request,
   output logic periodic_reset_request
);
   // ==========
   // zone 0 recovery window, 1 hot, 2 cold, 3 hysteresis band
   logic [4:0] cnt;
   assign rearm_high_crossed = zone == 2'h1;
   assign recovery_high_crossed = zone == 2'h0 || zone == 2'h2;
   assign rearm_low_crossed = zone == 2'h2;
   assign recovery_low_crossed = zone == 2'h0 || zone == 2'h1;
   // the timer never stops, the unit may only gate its outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cnt <= 5'h0;
      else cnt <= cnt + 5'h1;
   end
   assign wake_request = cnt[3:0] == 4'h8;
   assign periodic_reset_request = cnt == 5'h13;
endmodule : thermal_sensor_model

// ===== tb.sv
// self-checking testbench of the thermal restart unit
`timescale 1ns/1ps
module tb;
   localparam logic [31:0] opt_a = 32'h6008, sta_a = 32'h603c, ist_a = 32'h6040;
   localparam logic [31:0] icl_a = 32'h6044, ien_a = 32'h6048;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, q;
   logic [1:0] zone = 2'h3;
   logic rh, rch, rl, rcl, wr, pr, wake_irq, periodic_reset, restart_reset, unit_powered, irq;
   logic [15:0] restart_vector;
   int num_errors = 0, checks_done = 0, n_wake = 0, n_per = 0, n_rst = 0, w0, p0;
   always #25 pclk = ~pclk;
   thermal_sensor_model u_thermal_sensor_model (.pclk(pclk), .presetn(presetn), .zone(zone),
      .rearm_high_crossed(rh), .recovery_high_crossed(rch), .rearm_low_crossed(rl),
      .recovery_low_crossed(rcl), .wake_request(wr), .periodic_reset_request(pr));
   thermal_restart_control #(.RESET_CYCLES(1)) u_thermal_restart_control (.pclk(pclk), .presetn(presetn),
      .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .rearm_high_crossed(rh),
      .recovery_high_crossed(rch), .rearm_low_crossed(rl), .recovery_low_crossed(rcl),
      .wake_request(wr), .periodic_reset_request(pr), .wake_irq(wake_irq), .periodic_reset(periodic_reset),
      .restart_reset(restart_reset), .restart_vector(restart_vector), .unit_powered(unit_powered), .irq(irq));
   always @(posedge pclk) begin
      if (wake_irq === 1'b1) n_wake <= n_wake + 1;
      if (periodic_reset === 1'b1) n_per <= n_per + 1;
      if (restart_reset === 1'b1) n_rst <= n_rst + 1;
   end
   // ==========
   // bus and compare helpers
   task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // only the watchdog ends a wait for pready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : bus
   task automatic chk(input logic ok);
      checks_done++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("unexpected %0t check %0d failed", $time, checks_done);
      end
   endtask : chk
   task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
      bus(a, 1'b0, 32'h0);
      chk((q & m) === e);
   endtask : rd
   task automatic conclude;
      if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : conclude
   // ==========
   // scenarios
   task automatic t_defaults;
      rd(opt_a, 32'h0, 32'hc);
      rd(sta_a, 32'h1, 32'h1);
      bus(32'h0, 1'b0, 32'h0);
      chk(err === 1'b1);
   endtask : t_defaults
   task automatic t_refuse;
      zone <= 2'h0;
      repeat (6) @(posedge pclk);
      rd(sta_a, 32'h0, 32'h1);
      bus(opt_a, 1'b1, 32'h8);
      rd(opt_a, 32'h0, 32'h8);
      bus(ien_a, 1'b1, 32'h8);
      repeat (2) @(posedge pclk);
      chk(irq === 1'b1);
      bus(icl_a, 1'b1, 32'h8);
      repeat (2) @(posedge pclk);
      chk(irq === 1'b0);
      rd(ist_a, 32'h0, 32'h8);
   endtask : t_refuse
   task automatic t_select;
      zone <= 2'h1;
      repeat (6) @(posedge pclk);
      rd(sta_a, 32'h0, 32'h1);
      bus(opt_a, 1'b1, 32'h4);
      repeat (6) @(posedge pclk);
      rd(sta_a, 32'h1, 32'h1);
   endtask : t_select
   task automatic t_restart;
      bus(opt_a, 1'b1, 32'hc);
      rd(opt_a, 32'hc, 32'hc);
      chk(unit_powered === 1'b1);
      w0 = n_wake;
      p0 = n_per;
      repeat (40) @(posedge pclk);
      chk(n_wake == w0 && n_per == p0);
      zone <= 2'h0;
      repeat (8) @(posedge pclk);
      chk(n_rst == 1 && restart_vector === 16'hdffe);
      rd(opt_a, 32'h0, 32'hc);
      rd(ist_a, 32'h2, 32'h2);
   endtask : t_restart
   task automatic t_after;
      repeat (6) @(posedge pclk);
      rd(sta_a, 32'h0, 32'h1);
      bus(opt_a, 1'b1, 32'h8);
      rd(opt_a, 32'h0, 32'h8);
      w0 = n_wake;
      p0 = n_per;
      repeat (40) @(posedge pclk);
      chk(n_wake > w0 && n_per > p0);
      chk(n_rst == 1);
   endtask : t_after
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_defaults();
      t_refuse();
      t_select();
      t_restart();
      t_after();
      conclude();
   end
   initial begin
      #150000;
      num_errors++;
      conclude();
   end
endmodule : tb
